// ---- inc/tcc_regs.svh ----
// Register indices, control bit positions and reset values of the
// compare/capture block. Included by the package and the design.
// Byte address of a register is four times its index.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

`define TCC_IDX_W 10
`define TCC_CAP1_LO 10'h086
`define TCC_CAP1_HI 10'h087
`define TCC_CAP3_LO 10'h096
`define TCC_CAP3_HI 10'h097
`define TCC_CAP4_LO 10'h0A6
`define TCC_CAP4_HI 10'h0A7
`define TCC_CAP5_LO 10'h126
`define TCC_CAP5_HI 10'h127
`define TCC_CMP4A_LO 10'h0A8
`define TCC_CMP4A_HI 10'h0A9
`define TCC_CMP4B_HI 10'h0AA
`define TCC_CMP4B_LO 10'h0AB
`define TCC_CMP4C_LO 10'h0AC
`define TCC_CMP4C_HI 10'h0AD
`define TCC_CMP5A_LO 10'h128
`define TCC_CMP5A_HI 10'h129
`define TCC_CMP5B_LO 10'h12A
`define TCC_CMP5B_HI 10'h12B
`define TCC_CMP5C_LO 10'h12C
`define TCC_CMP5C_HI 10'h12D
`define TCC_CTRL 10'h140
`define TCC_STATUS 10'h141
`define TCC_CLEAR 10'h142
`define TCC_IRQ_EN 10'h143

// Control bits: [3:0] capture as top, [4] timer 1 from comparator,
// [10:5] waveform toggle per compare channel
`define TCC_CTRL_TOP_LSB 0
`define TCC_CTRL_ACMP_BIT 4
`define TCC_CTRL_WAVE_LSB 5
`define TCC_CTRL_W 11
// Status bits: [5:0] compare channels, [9:6] capture timers
`define TCC_STS_CAP_LSB 6
`define TCC_STS_W 10

`define TCC_RST_VALUE 16'h0000
`define TCC_RST_BYTE 8'h00

`endif

// ---- inc/tcc_pkg.sv ----
// Types of the compare/capture block.
// Assumes tcc_regs.svh on the include path.
`include "tcc_regs.svh"

package tcc_pkg;

  typedef enum logic [3:0] {
    TCC_K_NONE,
    TCC_K_CMP_LO,
    TCC_K_CMP_HI,
    TCC_K_CAP_LO,
    TCC_K_CAP_HI,
    TCC_K_CTRL,
    TCC_K_STATUS,
    TCC_K_CLEAR,
    TCC_K_IRQ_EN
  } tcc_kind_e;

  typedef struct packed {
    logic [5:0][15:0] cmp;
    logic [3:0][15:0] cap;
    logic [7:0] temp;
    logic [7:0] rd_hi;
    logic rd_lo;
    logic [`TCC_CTRL_W-1:0] ctrl;
    logic [`TCC_STS_W-1:0] sts;
    logic [`TCC_STS_W-1:0] ien;
    logic irq;
    logic [5:0] wave;
    logic [3:0] src_d;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tcc_state_s;

endpackage

// ---- design/tcc_top.sv ----
// Capture value registers of four 16-bit timers, compare value registers of two of them (timers 4 and 5), with
// an APB slave, one shared high-byte latch and a level interrupt.
// Assumes the counters, tick enables and capture pins are synchronous
// to clk; counters live outside this block.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_regs.svh"

module tcc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [3:0][15:0] timer_count_value,
  input wire logic [3:0] timer_tick,
  input wire logic [3:0] capture_input_pin,
  input wire logic acomp_out,
  output logic [3:0][15:0] capture_value,
  output logic [3:0] top_from_capture,
  output logic [5:0] compare_waveform_pin,
  output logic irq
);

  localparam logic [9:0] CMP_LO_IDX [6] = '{
    `TCC_CMP4A_LO, `TCC_CMP4B_LO, `TCC_CMP4C_LO,
    `TCC_CMP5A_LO, `TCC_CMP5B_LO, `TCC_CMP5C_LO};
  localparam logic [9:0] CMP_HI_IDX [6] = '{
    `TCC_CMP4A_HI, `TCC_CMP4B_HI, `TCC_CMP4C_HI,
    `TCC_CMP5A_HI, `TCC_CMP5B_HI, `TCC_CMP5C_HI};
  localparam logic [9:0] CAP_LO_IDX [4] = '{
    `TCC_CAP1_LO, `TCC_CAP3_LO, `TCC_CAP4_LO, `TCC_CAP5_LO};
  localparam logic [9:0] CAP_HI_IDX [4] = '{
    `TCC_CAP1_HI, `TCC_CAP3_HI, `TCC_CAP4_HI, `TCC_CAP5_HI};

  tcc_pkg::tcc_state_s st_reg;
  tcc_pkg::tcc_state_s st_next;
  tcc_pkg::tcc_kind_e kind;
  logic [2:0] chan;
  logic [7:0] rd_byte;
  logic [7:0] rd_hi_byte;
  logic [9:0] idx;
  logic setup;
  logic done;
  logic [5:0] match;
  logic [3:0] src;
  logic [3:0] cap_evt;
  logic [3:0] top_hit;
  logic [3:0] top_mode;

  assign idx = paddr[11:2];
  assign setup = psel && !penable;
  assign done = psel && penable && st_reg.pready;
  assign top_mode = st_reg.ctrl[`TCC_CTRL_TOP_LSB +: 4];

  // Channels 0..2 belong to timer 4 (index 2), 3..5 to timer 5
  for (genvar c = 0; c < 6; c++) begin : g_cmp
    localparam int T = (c < 3) ? 2 : 3;
    assign match[c] = timer_tick[T] &&
      (timer_count_value[T] == st_reg.cmp[c]);

    a_cmp_match_flag: assert property (@(posedge clk) disable iff (!rst_n)
      match[c] |=> st_reg.sts[c])
      else $error("compare match did not set its flag");

    a_cmp_wave_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      match[c] && st_reg.ctrl[`TCC_CTRL_WAVE_LSB + c]
      |=> compare_waveform_pin[c] != $past(compare_waveform_pin[c]))
      else $error("waveform pin did not toggle on match");

    a_cmp_atomic_write: assert property (@(posedge clk) disable iff (!rst_n)
      done && pwrite && pstrb[0] && kind == tcc_pkg::TCC_K_CMP_LO && chan == 3'(c)
      |=> st_reg.cmp[c] == {$past(st_reg.temp), $past(pwdata[7:0])})
      else $error("compare value not loaded as latch plus low byte");

    a_irq_on_match: assert property (@(posedge clk) disable iff (!rst_n)
      match[c] && st_reg.ien[c] && !(done && pwrite) |=> irq)
      else $error("enabled compare match did not raise the interrupt");

    // A high-byte write alone must leave the compare value untouched
    a_cmp_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !(done && pwrite && kind == tcc_pkg::TCC_K_CMP_LO && chan == 3'(c))
      |=> $stable(st_reg.cmp[c]))
      else $error("compare value moved without a low-byte write");

    a_wave_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !match[c] |=> $stable(compare_waveform_pin[c]))
      else $error("waveform pin moved without a match");
  end

  // Timer 1 may take its capture event from the analog comparator
  for (genvar t = 0; t < 4; t++) begin : g_cap
    if (t == 0) begin : g_src1
      assign src[t] = st_reg.ctrl[`TCC_CTRL_ACMP_BIT] ? acomp_out
                                                      : capture_input_pin[t];
    end else begin : g_srcn
      assign src[t] = capture_input_pin[t];
    end
    // Captures are blocked while the register serves as top,
    // otherwise the top would move under the counter.
    assign cap_evt[t] = src[t] && !st_reg.src_d[t] && !top_mode[t];
    assign top_hit[t] = top_mode[t] && timer_tick[t] &&
      (timer_count_value[t] == st_reg.cap[t]);

    a_cap_snapshot: assert property (@(posedge clk) disable iff (!rst_n)
      cap_evt[t] |=> capture_value[t] == $past(timer_count_value[t]))
      else $error("capture did not store the counter");

    a_cap_top_hold: assert property (@(posedge clk) disable iff (!rst_n)
      top_mode[t] && !(done && pwrite && kind == tcc_pkg::TCC_K_CAP_LO)
      |=> $stable(st_reg.cap[t]))
      else $error("capture register moved while used as top");

    a_cap_read_pair: assert property (@(posedge clk) disable iff (!rst_n)
      setup && !pwrite && kind == tcc_pkg::TCC_K_CAP_LO && chan == 3'(t)
      ##1 done
      |=> {st_reg.temp, prdata[7:0]} == $past(st_reg.cap[t], 2))
      else $error("capture bytes returned from different values");

    a_cap_flag: assert property (@(posedge clk) disable iff (!rst_n)
      cap_evt[t] |=> st_reg.sts[`TCC_STS_CAP_LSB + t])
      else $error("capture event did not set its flag");

    a_top_flag: assert property (@(posedge clk) disable iff (!rst_n)
      top_hit[t] |=> st_reg.sts[`TCC_STS_CAP_LSB + t])
      else $error("counter reaching top did not set the capture flag");

    // Nothing but an edge or a CPU write may move the register
    a_cap_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !cap_evt[t] && !(done && pwrite && kind == tcc_pkg::TCC_K_CAP_LO && chan == 3'(t))
      |=> $stable(st_reg.cap[t]))
      else $error("capture register moved without an event or write");

    // Software may load the register for use as top
    a_cap_write: assert property (@(posedge clk) disable iff (!rst_n)
      done && pwrite && pstrb[0] && kind == tcc_pkg::TCC_K_CAP_LO && chan == 3'(t) &&
      !cap_evt[t]
      |=> capture_value[t] == {$past(st_reg.temp), $past(pwdata[7:0])})
      else $error("capture value not loaded as latch plus low byte");
  end

  // Address decode; also picks the byte a read returns
  always_comb begin
    kind = tcc_pkg::TCC_K_NONE;
    chan = 3'h0;
    rd_byte = 8'h00;
    rd_hi_byte = 8'h00;
    for (int c = 0; c < 6; c++) begin
      if (idx == CMP_LO_IDX[c]) begin
        kind = tcc_pkg::TCC_K_CMP_LO;
        chan = 3'(c);
        rd_byte = st_reg.cmp[c][7:0];
        rd_hi_byte = st_reg.cmp[c][15:8];
      end else if (idx == CMP_HI_IDX[c]) begin
        kind = tcc_pkg::TCC_K_CMP_HI;
        chan = 3'(c);
        rd_byte = st_reg.temp;
      end
    end
    for (int t = 0; t < 4; t++) begin
      if (idx == CAP_LO_IDX[t]) begin
        kind = tcc_pkg::TCC_K_CAP_LO;
        chan = 3'(t);
        rd_byte = st_reg.cap[t][7:0];
        rd_hi_byte = st_reg.cap[t][15:8];
      end else if (idx == CAP_HI_IDX[t]) begin
        kind = tcc_pkg::TCC_K_CAP_HI;
        chan = 3'(t);
        rd_byte = st_reg.temp;
      end
    end
    if (idx == `TCC_CTRL) begin
      kind = tcc_pkg::TCC_K_CTRL;
    end else if (idx == `TCC_STATUS) begin
      kind = tcc_pkg::TCC_K_STATUS;
    end else if (idx == `TCC_CLEAR) begin
      kind = tcc_pkg::TCC_K_CLEAR;
    end else if (idx == `TCC_IRQ_EN) begin
      kind = tcc_pkg::TCC_K_IRQ_EN;
    end
    if (paddr[1:0] != 2'b00) begin
      kind = tcc_pkg::TCC_K_NONE;
      // Misaligned: no register answers, so read as zero
      rd_byte = 8'h00;
      rd_hi_byte = 8'h00;
    end
  end

  always_comb begin
    logic [`TCC_STS_W-1:0] clr;
    logic [`TCC_STS_W-1:0] set;
    clr = '0;
    set = {cap_evt | top_hit, match};
    st_next = st_reg;
    st_next.src_d = src;
    // Zero wait states: answer in the cycle after setup
    st_next.pready = setup;
    st_next.pslverr = setup && kind == tcc_pkg::TCC_K_NONE;
    if (setup && !pwrite) begin
      // Snapshot both bytes at once so a capture in between
      // cannot tear the pair.
      st_next.rd_hi = rd_hi_byte;
      st_next.rd_lo = (kind == tcc_pkg::TCC_K_CMP_LO) ||
                      (kind == tcc_pkg::TCC_K_CAP_LO);
      case (kind)
        tcc_pkg::TCC_K_CTRL: st_next.prdata = 32'(st_reg.ctrl);
        tcc_pkg::TCC_K_STATUS: st_next.prdata = 32'(st_reg.sts);
        tcc_pkg::TCC_K_IRQ_EN: st_next.prdata = 32'(st_reg.ien);
        default: st_next.prdata = 32'(rd_byte);
      endcase
    end
    if (done && !pwrite && st_reg.rd_lo) begin
      st_next.temp = st_reg.rd_hi;
    end
    // Writes land only in the access phase; byte lane 0 must be set
    if (done && pwrite && pstrb[0]) begin
      case (kind)
        tcc_pkg::TCC_K_CMP_HI,
        tcc_pkg::TCC_K_CAP_HI: st_next.temp = pwdata[7:0];
        tcc_pkg::TCC_K_CMP_LO:
          st_next.cmp[chan] = {st_reg.temp, pwdata[7:0]};
        tcc_pkg::TCC_K_CAP_LO:
          st_next.cap[chan[1:0]] = {st_reg.temp, pwdata[7:0]};
        tcc_pkg::TCC_K_CTRL: st_next.ctrl = pwdata[`TCC_CTRL_W-1:0];
        tcc_pkg::TCC_K_CLEAR: clr = pwdata[`TCC_STS_W-1:0];
        tcc_pkg::TCC_K_IRQ_EN: st_next.ien = pwdata[`TCC_STS_W-1:0];
        default: ;
      endcase
    end
    // A hardware capture beats a software write in the same cycle
    for (int t = 0; t < 4; t++) begin
      if (cap_evt[t]) begin
        st_next.cap[t] = timer_count_value[t];
      end
    end
    for (int c = 0; c < 6; c++) begin
      if (match[c] && st_reg.ctrl[`TCC_CTRL_WAVE_LSB + c]) begin
        st_next.wave[c] = !st_reg.wave[c];
      end
    end
    // Set wins over a clear in the same cycle
    st_next.sts = (st_reg.sts & ~clr) | set;
    st_next.irq = |(st_next.sts & st_next.ien);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pready = st_reg.pready;
  assign prdata = st_reg.prdata;
  assign pslverr = st_reg.pslverr;
  assign capture_value = st_reg.cap;
  assign top_from_capture = top_mode;
  assign compare_waveform_pin = st_reg.wave;
  assign irq = st_reg.irq;

  a_temp_shared: assert property (@(posedge clk) disable iff (!rst_n)
    done && pwrite && pstrb[0] &&
    (kind == tcc_pkg::TCC_K_CMP_HI || kind == tcc_pkg::TCC_K_CAP_HI)
    |=> st_reg.temp == $past(pwdata[7:0]))
    else $error("high byte write did not reach the shared latch");

  a_hi_read_temp: assert property (@(posedge clk) disable iff (!rst_n)
    setup && !pwrite &&
    (kind == tcc_pkg::TCC_K_CMP_HI || kind == tcc_pkg::TCC_K_CAP_HI)
    |=> prdata == {24'h000000, $past(st_reg.temp)} && pready)
    else $error("high byte read did not return the latch");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    irq == |(st_reg.sts & st_reg.ien))
    else $error("interrupt level does not follow enabled status");

  // Zero wait states: every setup is answered in the next cycle
  a_bus_ready: assert property (@(posedge clk) disable iff (!rst_n)
    setup |=> pready)
    else $error("no ready in the cycle after setup");

  a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  // Refused accesses answer with an error and read as zero
  a_bus_err: assert property (@(posedge clk) disable iff (!rst_n)
    setup && kind == tcc_pkg::TCC_K_NONE |=> pslverr)
    else $error("unmapped access did not flag an error");

  a_err_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    setup && !pwrite && kind == tcc_pkg::TCC_K_NONE |=> prdata == 32'h00000000)
    else $error("unmapped read returned nonzero data");

  a_strb_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    done && pwrite && !pstrb[0]
    |=> $stable(st_reg.temp) && $stable(st_reg.cmp) && $stable(st_reg.ctrl))
    else $error("write without byte lane 0 changed a register");

  a_lo_read_latch: assert property (@(posedge clk) disable iff (!rst_n)
    done && !pwrite && st_reg.rd_lo |=> st_reg.temp == $past(st_reg.rd_hi))
    else $error("low byte read did not load the latch");

  a_hi_read_keep: assert property (@(posedge clk) disable iff (!rst_n)
    done && !pwrite && !st_reg.rd_lo |=> $stable(st_reg.temp))
    else $error("high byte read disturbed the latch");

  // Set wins: a clear may leave only bits that a new event sets
  a_sts_clear: assert property (@(posedge clk) disable iff (!rst_n)
    done && pwrite && pstrb[0] && kind == tcc_pkg::TCC_K_CLEAR
    |=> (st_reg.sts & $past(pwdata[`TCC_STS_W-1:0]) &
         ~$past({cap_evt | top_hit, match})) == '0)
    else $error("cleared status bit stayed set");

  a_ctrl_top: assert property (@(posedge clk) disable iff (!rst_n)
    done && pwrite && pstrb[0] && kind == tcc_pkg::TCC_K_CTRL
    |=> top_from_capture == $past(pwdata[`TCC_CTRL_TOP_LSB +: 4]))
    else $error("top selection did not follow the control write");

  // Read data stands until the next read setup
  a_prdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(setup && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read setup");

endmodule // tcc_top

`default_nettype wire

// ---- verif/tcc_timer_model.sv ----
// Far-side timers: four free counters with a shared run enable.
// Assumes the same clk and rst_n as the compare/capture block.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic [3:0][15:0] count,
  output logic [3:0] tick
);
  // Distinct steps keep the four counters apart for capture checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (run) begin
      for (int i = 0; i < 4; i++) begin
        count[i] <= count[i] + 16'(i + 1);
      end
    end
  end
  // Stopped timers give no ticks, so no stray matches
  assign tick = {4{run}};
endmodule // tcc_timer_model
`default_nettype wire

// ---- verif/tb_timer_compare_capture_regs.sv ----
// Self-checking bench of the compare/capture block over APB.
// Assumes tcc_regs.svh on the include path and the timer model.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_regs.svh"
module tb_timer_compare_capture_regs;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, run = 1'b0, acomp = 1'b0, e;
  logic [3:0][15:0] cnt, capv;
  logic [3:0] tick, pin = 4'h0, topc, strb = 4'hF;
  logic [5:0] wave;
  logic [15:0] v;
  int n_mismatch = 0, compares = 0;
  always #5 clk = ~clk;
  tcc_timer_model tmr (.clk(clk), .rst_n(rst_n), .run(run), .count(cnt), .tick(tick));
  tcc_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timer_count_value(cnt), .timer_tick(tick),
    .capture_input_pin(pin), .acomp_out(acomp), .capture_value(capv),
    .top_from_capture(topc), .compare_waveform_pin(wave), .irq(irq));
  task stop_test;
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Old pready is seen at the edge, so the request holds until then
  task apb(input logic w, input logic [9:0] idx, input logic [15:0] d,
           output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff (pready === 1'b1));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [9:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, r, e);
  endtask
  // Low byte first: it loads the shared latch for the high read
  task rd16(input logic [9:0] lo, input logic [9:0] hi, output logic [15:0] val);
    logic [31:0] a;
    apb(1'b0, lo, 16'h0, a, e);
    apb(1'b0, hi, 16'h0, r, e);
    val = {r[7:0], a[7:0]};
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd16(`TCC_CAP5_LO, `TCC_CAP5_HI, v);
    chk(v, 32'h0);
    rd16(`TCC_CMP5C_LO, `TCC_CMP5C_HI, v);
    chk(v, 32'h0);
    wr(`TCC_CMP4B_HI, 16'h00A5);
    wr(`TCC_CMP4B_LO, 16'h005A);
    rd16(`TCC_CMP4B_LO, `TCC_CMP4B_HI, v);
    chk(v, 32'hA55A);
    // Lane 0 off: neither the latch nor the value may move
    strb <= 4'h0;
    wr(`TCC_CMP4B_HI, 16'h00FF);
    wr(`TCC_CMP4B_LO, 16'h00EE);
    strb <= 4'hF;
    rd16(`TCC_CMP4B_LO, `TCC_CMP4B_HI, v);
    chk(v, 32'hA55A);
    // High byte aimed at one register lands in another's low write
    wr(`TCC_CMP5A_HI, 16'h003C);
    wr(`TCC_CMP5C_LO, 16'h0011);
    rd16(`TCC_CMP5C_LO, `TCC_CMP5C_HI, v);
    chk(v, 32'h3C11);
    rd16(`TCC_CMP5A_LO, `TCC_CMP5A_HI, v);
    chk(v, 32'h0);
    wr(`TCC_CMP4A_HI, 16'h0000);
    wr(`TCC_CMP4A_LO, 16'h0012);
    wr(`TCC_IRQ_EN, 16'h0001);
    wr(`TCC_CTRL, 16'h0020);
    run <= 1'b1;
    for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge clk);
    run <= 1'b0;
    chk(irq, 1'b1);
    chk(wave[0], 1'b1);
    apb(1'b0, `TCC_STATUS, 16'h0, r, e);
    chk(r[0], 1'b1);
    wr(`TCC_CLEAR, 16'h03FF);
    apb(1'b0, `TCC_STATUS, 16'h0, r, e);
    chk(r, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    pin[1] <= 1'b1;
    repeat (3) @(posedge clk);
    pin[1] <= 1'b0;
    rd16(`TCC_CAP3_LO, `TCC_CAP3_HI, v);
    chk(v, cnt[1]);
    chk(capv[1], cnt[1]);
    apb(1'b0, `TCC_STATUS, 16'h0, r, e);
    chk(r[7], 1'b1);
    wr(`TCC_CTRL, 16'h0010);
    acomp <= 1'b1;
    repeat (3) @(posedge clk);
    rd16(`TCC_CAP1_LO, `TCC_CAP1_HI, v);
    chk(v, cnt[0]);
    wr(`TCC_CTRL, 16'h000F);
    repeat (2) @(posedge clk);
    chk(topc, 4'hF);
    // Top mode: pin edges ignored, reaching the value raises the flag
    v = cnt[2] + 16'h0003;
    wr(`TCC_CAP4_HI, {8'h00, v[15:8]});
    wr(`TCC_CAP4_LO, {8'h00, v[7:0]});
    pin[2] <= 1'b1;
    run <= 1'b1;
    repeat (3) @(posedge clk);
    run <= 1'b0;
    pin[2] <= 1'b0;
    chk(capv[2], v);
    apb(1'b0, `TCC_STATUS, 16'h0, r, e);
    chk(r[8], 1'b1);
    apb(1'b0, 10'h150, 16'h0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    stop_test;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
endmodule // tb_timer_compare_capture_regs
`default_nettype wire
